/* design/reset_seq_pkg.sv */
// Shared constants and types for the start-up sequencer and its controller.
package reset_seq_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int INT_PULSE_NS = 1000;
  localparam int INT_PULSE_CYC = INT_PULSE_NS / CLK_PERIOD_NS;
  localparam int START_LAT = 3;
  localparam int CYC_MODE0 = 8204;
  localparam int CYC_MODE1 = 555386;
  localparam int CYC_MODE2 = 73745;
  localparam int CYC_MODE3 = 620927;
  localparam int CYC_MODE4 = 53388;
  localparam int CYC_MODE5 = 9;
  // ****************************************
  // Start-up modes
  // ****************************************
  localparam logic [2:0] MODE_LAST_FULL = 3'h3;
  localparam logic [2:0] MODE_LAST_DATA = 3'h4;
  localparam logic [2:0] MODE_BYPASS = 3'h5;
  localparam logic [2:0] MODE_RAM_TEST = 3'h6;
  localparam logic [2:0] MODE_RESERVED = 3'h7;
  // ****************************************
  // Device register map and memory
  // ****************************************
  localparam logic [15:0] ADDR_PENDING = 16'h8004;
  localparam logic [15:0] ADDR_SELFTEST_HIGH = 16'h807a;
  localparam logic [15:0] ADDR_AUTOLOAD_LOW = 16'h807b;
  localparam logic [15:0] ADDR_AUTOLOAD_HIGH = 16'h807c;
  localparam logic [11:0] DATA_PAGE = 12'h000;
  localparam logic [11:0] CFG_PAGE = 12'h400;
  localparam int PEND_CMP = 5;
  localparam int PEND_CHK = 4;
  localparam int PEND_RAM = 3;
  localparam int RAM_WORDS = 16;
  localparam int CFG_BYTES = 16;
  localparam logic [15:0] EE_CMD = 16'h0300;
  localparam logic [7:0] EE_CMD_BITS = 8'h10;
  localparam logic [7:0] EE_PASS_BITS = 8'h98;
  // ****************************************
  // Controller register map
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] DEV_ADDR_OFF = 8'h08;
  localparam logic [7:0] DEV_DATA_OFF = 8'h0c;
  localparam logic [7:0] SOFT_RST_OFF = 8'h10;
  localparam int CTRL_RELEASE = 0;
  localparam int CTRL_RUN = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_ACK = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [7:0] {
    st_start = 8'h01,
    st_ram = 8'h02,
    st_clear = 8'h04,
    st_load = 8'h08,
    st_wait = 8'h10,
    st_idle = 8'h20,
    st_active = 8'h40,
    st_safe = 8'h80
  } seq_state_e;
endpackage

/* design/seq_link_if.sv */
// Pin-level link between the start-up sequencer and its controller.
`timescale 1ns/1ps
interface seq_link_if;
  logic hard_reset_n;
  logic run;
  logic ack_n;
  logic ready;
  logic int_n;
  logic [2:0] ctrl_mode_o;
  logic ctrl_mode_oe;
  logic [2:0] dev_mode_o;
  logic dev_mode_oe;
  logic [2:0] mode_pin;
  logic reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic soft_reset;
  logic [2:0] soft_mode;
  // Resolves the shared mode pins; an undriven pin reads low.
  assign mode_pin = dev_mode_oe ? dev_mode_o : (ctrl_mode_oe ? ctrl_mode_o : 3'h0);
  modport dev(input hard_reset_n, run, ack_n, mode_pin, reg_rd, reg_addr, soft_reset,
              soft_mode, output ready, int_n, dev_mode_o, dev_mode_oe, reg_rdata, reg_rvalid);
  modport ctrl(input ready, int_n, reg_rdata, reg_rvalid, output hard_reset_n, run, ack_n,
               ctrl_mode_o, ctrl_mode_oe, reg_rd, reg_addr, soft_reset, soft_mode);
endinterface

/* design/seq_controller.sv */
// Controller end: AXI4-Lite registers that drive the sequencer pins.
`timescale 1ns/1ps
module seq_controller import reset_seq_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  seq_link_if.ctrl link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic [1:0] st_s1;
  logic [1:0] st_s2;
  logic [8:0] dev_data;
  logic [31:0] rd_mux;

  function automatic logic mapped(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    mapped = (w == CTRL_OFF) || (w == STATUS_OFF) || (w == DEV_ADDR_OFF) ||
             (w == DEV_DATA_OFF) || (w == SOFT_RST_OFF);
  endfunction

  assign do_wr = aw_got && w_got && !s_axi_bvalid;

  // Takes address and data in either order and answers once both are in.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Applies register writes to the link pins and request strobes.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link.hard_reset_n <= 1'b0;
      link.ctrl_mode_oe <= 1'b1;
      link.ctrl_mode_o <= 3'h0;
      link.run <= 1'b0;
      link.ack_n <= 1'b1;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 16'h0000;
      link.soft_reset <= 1'b0;
      link.soft_mode <= 3'h0;
    end else begin
      link.reg_rd <= 1'b0;
      link.soft_reset <= 1'b0;
      if (do_wr && w_strb[0]) begin
        case ({aw_addr[7:2], 2'h0})
          CTRL_OFF: begin
            link.hard_reset_n <= w_data[CTRL_RELEASE];
            link.ctrl_mode_oe <= !w_data[CTRL_RELEASE];
            link.run <= w_data[CTRL_RUN];
            link.ack_n <= !w_data[CTRL_ACK];
            if (w_data[CTRL_MODE_LSB+:3] != MODE_RESERVED) begin
              link.ctrl_mode_o <= w_data[CTRL_MODE_LSB+:3];
            end
          end
          DEV_ADDR_OFF: begin
            link.reg_addr[7:0] <= w_data[7:0];
            if (w_strb[1]) begin
              link.reg_addr[15:8] <= w_data[15:8];
            end
            link.reg_rd <= 1'b1;
          end
          SOFT_RST_OFF: begin
            link.soft_reset <= 1'b1;
            link.soft_mode <= w_data[2:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Brings the device ready and interrupt outputs into this clock domain.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_s1 <= 2'h0;
      st_s2 <= 2'h0;
    end else begin
      st_s1 <= {link.int_n, link.ready};
      st_s2 <= st_s1;
    end
  end

  // Holds the last device register answer until the next request.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dev_data <= 9'h000;
    end else if (link.reg_rvalid) begin
      dev_data <= {1'b1, link.reg_rdata};
    end else if (link.reg_rd) begin
      dev_data <= 9'h000;
    end
  end

  // Selects the word for a register read.
  always_comb begin
    rd_mux = 32'h0;
    case ({s_axi_araddr[7:2], 2'h0})
      CTRL_OFF: rd_mux = {26'h0, !link.ack_n, link.ctrl_mode_o, link.run, link.hard_reset_n};
      STATUS_OFF: rd_mux = {30'h0, st_s2};
      DEV_ADDR_OFF: rd_mux = {16'h0, link.reg_addr};
      DEV_DATA_OFF: rd_mux = {23'h0, dev_data};
      default: rd_mux = 32'h0;
    endcase
  end

  // Answers one read at a time, one cycle after the address is taken.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

/* design/startup_sequencer.sv */
// Device end: reset, start-up mode and initialization sequencer.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module startup_sequencer import reset_seq_pkg::*; #(
  parameter int CYC0 = CYC_MODE0,
  parameter int CYC1 = CYC_MODE1,
  parameter int CYC2 = CYC_MODE2,
  parameter int CYC3 = CYC_MODE3,
  parameter int CYC4 = CYC_MODE4
) (
  input wire logic mclk,
  input wire logic rst,
  seq_link_if.dev link,
  input wire logic eeprom_serial_in,
  input wire logic ram_fault_inject,
  output logic bus_active,
  output logic safe_state
);
  logic core_rst;
  logic rel1;
  logic rel2;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic run_d;
  logic [2:0] mode;
  seq_state_e state;
  logic [19:0] cnt;
  logic [3:0] idx;
  logic [1:0] rph;
  logic [7:0] mem [RAM_WORDS];
  logic [7:0] cfg [CFG_BYTES];
  logic [7:0] rd_word;
  logic [7:0] expect_word;
  logic ram_bad;
  logic ram_last;
  logic eeprom_serial_clock;
  logic eeprom_serial_out;
  logic eeprom_select_n;
  logic [7:0] bcnt;
  logic [1:0] ph;
  logic pass;
  logic [6:0] sh;
  logic [7:0] sum;
  logic [7:0] ck;
  logic [7:0] boff;
  logic [7:0] new_byte;
  logic [4:0] byte_idx;
  logic bit_end;
  logic byte_end;
  logic pass_end;
  logic cmp_bad;
  logic chk_bad;
  logic [7:0] ev;
  logic [7:0] pend;
  logic [7:0] fail_lo;
  logic [4:0] pcnt;
  logic soft_full;
  logic soft_data;

  // Start-up length, less the release latency, for the sampled mode.
  function automatic logic [19:0] mode_total(input logic [2:0] m);
    case (m)
      3'h0: mode_total = 20'(CYC0 - START_LAT);
      3'h1: mode_total = 20'(CYC1 - START_LAT);
      3'h2: mode_total = 20'(CYC2 - START_LAT);
      3'h3: mode_total = 20'(CYC3 - START_LAT);
      3'h4: mode_total = 20'(CYC4 - START_LAT);
      default: mode_total = 20'(CYC_MODE5 - START_LAT);
    endcase
  endfunction

  // ****************************************
  // Reset, pins and mode capture
  // ****************************************
  // Hard reset stops the core at once; its release is synchronised.
  assign core_rst = rst | ~link.hard_reset_n;
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      rel1 <= 1'b0;
      rel2 <= 1'b0;
    end else begin
      rel1 <= 1'b1;
      rel2 <= rel1;
    end
  end

  // Two-stage synchronisers for run, acknowledge, EEPROM data and mode pins.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      run_d <= 1'b0;
    end else begin
      pin_s1 <= {link.run, link.ack_n, eeprom_serial_in, link.mode_pin};
      pin_s2 <= pin_s1;
      run_d <= pin_s2[5];
    end
  end

  // Mode follows the pins while held in reset and freezes at release.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode <= 3'h0;
    end else if (!rel2) begin
      mode <= pin_s2[2:0];
    end
  end

  // ****************************************
  // Sequence control
  // ****************************************
  assign rd_word = mem[idx] ^ {7'h00, ram_fault_inject};
  assign expect_word = rph[1] ? ~{4'h0, idx} : {4'h0, idx};
  assign ram_bad = (state == st_ram) && rph[0] && (rd_word != expect_word);
  assign ram_last = (idx == 4'hf) && (rph == 2'h3);

  // Walks the steps that the sampled mode selects.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      state <= st_start;
      link.ready <= 1'b0;
      bus_active <= 1'b0;
      safe_state <= 1'b0;
    end else if (rel2) begin
      case (state)
        st_start: begin
          case (mode)
            3'h2, 3'h3, MODE_RAM_TEST: state <= st_ram;
            MODE_BYPASS: state <= st_wait;
            MODE_RESERVED: state <= st_safe;
            default: state <= st_clear;
          endcase
        end
        st_ram: begin
          if (ram_bad) begin
            state <= st_safe;
          end else if (ram_last && mode == MODE_RAM_TEST) begin
            state <= st_idle;
            link.ready <= 1'b1;
          end else if (ram_last) begin
            state <= st_clear;
          end
        end
        st_clear: begin
          state <= (!mode[2] && mode[0]) ? st_load : st_wait;
        end
        st_load: begin
          if (cmp_bad || chk_bad) begin
            state <= st_safe;
          end else if (pass_end && pass) begin
            state <= st_wait;
          end
        end
        st_wait: begin
          if (cnt == mode_total(mode)) begin
            state <= st_idle;
            link.ready <= 1'b1;
          end
        end
        st_idle: begin
          if (pin_s2[5] && !run_d) begin
            state <= st_active;
            bus_active <= 1'b1;
          end
        end
        st_active: state <= st_active;
        st_safe: state <= st_safe;
        default: state <= st_safe;
      endcase
      if (state == st_safe || (state == st_start && mode == MODE_RESERVED)) begin
        safe_state <= 1'b1;
      end
      if (ram_bad || cmp_bad || chk_bad) begin
        safe_state <= 1'b1;
      end
    end
  end

  // Counts cycles from release until the sequence settles.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      cnt <= 20'h00000;
    end else if (rel2 && state != st_idle && state != st_active && state != st_safe) begin
      cnt <= cnt + 20'h00001;
    end
  end

  // Steps the self-test address and pass.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      idx <= 4'h0;
      rph <= 2'h0;
    end else if (rel2 && state == st_ram) begin
      idx <= idx + 4'h1;
      if (idx == 4'hf) begin
        rph <= rph + 2'h1;
      end
    end
  end

  // ****************************************
  // EEPROM load
  // ****************************************
  assign boff = bcnt - EE_CMD_BITS;
  assign byte_idx = boff[7:3];
  assign new_byte = {sh, pin_s2[3]};
  assign bit_end = (state == st_load) && !eeprom_select_n && (ph == 2'h3);
  assign byte_end = bit_end && (bcnt >= EE_CMD_BITS) && (boff[2:0] == 3'h7);
  assign pass_end = bit_end && (bcnt == EE_PASS_BITS - 8'h01);
  assign cmp_bad = byte_end && pass &&
                   (new_byte != (byte_idx[4] ? ck : cfg[byte_idx[3:0]]));
  assign chk_bad = pass_end && pass && (sum != 8'h00);

  // Reads the image twice: once to load it, once to check it.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      eeprom_select_n <= 1'b1;
      eeprom_serial_clock <= 1'b0;
      eeprom_serial_out <= 1'b0;
      bcnt <= 8'h00;
      ph <= 2'h0;
      pass <= 1'b0;
      sh <= 7'h00;
      sum <= 8'h00;
      ck <= 8'h00;
    end else if (rel2) begin
      if (state != st_load) begin
        eeprom_select_n <= 1'b1;
        eeprom_serial_clock <= 1'b0;
      end else if (eeprom_select_n) begin
        eeprom_select_n <= 1'b0;
      end else begin
        ph <= ph + 2'h1;
        eeprom_serial_clock <= (ph == 2'h1) || (ph == 2'h2);
        if (ph == 2'h0) begin
          eeprom_serial_out <= (bcnt < EE_CMD_BITS) ? EE_CMD[4'hf - bcnt[3:0]] : 1'b0;
        end
        if (ph == 2'h3) begin
          sh <= new_byte[6:0];
          bcnt <= bcnt + 8'h01;
          if (byte_end && !pass) begin
            sum <= sum + new_byte;
            if (byte_idx[4]) begin
              ck <= new_byte;
            end
          end
          if (pass_end) begin
            bcnt <= 8'h00;
            pass <= 1'b1;
            eeprom_select_n <= 1'b1;
          end
        end
      end
    end
  end

  // The mode pins turn into EEPROM outputs once reset is released.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      link.dev_mode_oe <= 1'b0;
    end else begin
      link.dev_mode_oe <= rel2;
    end
  end
  assign link.dev_mode_o = {eeprom_serial_clock, eeprom_serial_out, eeprom_select_n};

  // ****************************************
  // Memory
  // ****************************************
  assign soft_full = link.soft_reset && (link.soft_mode <= MODE_LAST_FULL) && rel2;
  assign soft_data = link.soft_reset && (link.soft_mode <= MODE_LAST_DATA) && rel2;

  // Data memory: self-test patterns and clearing.
  always_ff @(posedge mclk) begin
    if (rel2 && state == st_ram && rph == 2'h0) begin
      mem[idx] <= {4'h0, idx};
    end else if (rel2 && state == st_ram && rph == 2'h2) begin
      mem[idx] <= ~mem[idx];
    end else if ((rel2 && state == st_clear && mode <= MODE_LAST_DATA) || soft_data) begin
      for (int i = 0; i < RAM_WORDS; i++) begin
        mem[i] <= 8'h00;
      end
    end
  end

  // Configuration tables: EEPROM image and clearing.
  always_ff @(posedge mclk) begin
    if (rel2 && byte_end && !pass && !byte_idx[4]) begin
      cfg[byte_idx[3:0]] <= new_byte;
    end else if ((rel2 && state == st_clear && mode <= MODE_LAST_FULL) || soft_full) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg[i] <= 8'h00;
      end
    end
  end

  // ****************************************
  // Fault flags, interrupt and register reads
  // ****************************************
  always_comb begin
    ev = 8'h00;
    ev[PEND_RAM] = ram_bad;
    ev[PEND_CMP] = cmp_bad;
    ev[PEND_CHK] = chk_bad && !cmp_bad;
  end

  // Fault flags set over a read-clear in the same cycle.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      pend <= 8'h00;
      fail_lo <= 8'h00;
    end else if (rel2) begin
      if (link.reg_rd && link.reg_addr == ADDR_PENDING) begin
        pend <= ev;
      end else begin
        pend <= pend | ev;
      end
      if (cmp_bad) begin
        fail_lo <= {3'h0, byte_idx};
      end else if (soft_full) begin
        fail_lo <= 8'h00;
      end
    end
  end

  // Level mode waits for acknowledge; pulse mode times out.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      link.int_n <= 1'b1;
      pcnt <= 5'h00;
    end else if (rel2) begin
      if (|ev) begin
        link.int_n <= 1'b0;
        pcnt <= pin_s2[4] ? 5'h00 : 5'(INT_PULSE_CYC);
      end else if (pcnt != 5'h00) begin
        pcnt <= pcnt - 5'h01;
      end else if (!pin_s2[4]) begin
        link.int_n <= 1'b1;
      end
    end
  end

  // Answers a register read one cycle after the request.
  always_ff @(posedge mclk or posedge core_rst) begin
    if (core_rst) begin
      link.reg_rvalid <= 1'b0;
      link.reg_rdata <= 8'h00;
    end else begin
      link.reg_rvalid <= link.reg_rd && rel2;
      link.reg_rdata <= 8'h00;
      if (link.reg_addr == ADDR_SELFTEST_HIGH) begin
        link.reg_rdata <= {mode, 5'h00};
      end else if (link.reg_addr == ADDR_AUTOLOAD_LOW) begin
        link.reg_rdata <= fail_lo;
      end else if (link.reg_addr == ADDR_PENDING) begin
        link.reg_rdata <= pend;
      end else if (link.reg_addr[15:4] == DATA_PAGE) begin
        link.reg_rdata <= mem[link.reg_addr[3:0]];
      end else if (link.reg_addr[15:4] == CFG_PAGE) begin
        link.reg_rdata <= cfg[link.reg_addr[3:0]];
      end
    end
  end
endmodule

/* design/seq_link_if_note_unused.sv */
// Holds no logic; the link itself lives in seq_link_if.
`timescale 1ns/1ps

/* testbench/seq_link_monitor.sv */
// Checker for the pin link between the sequencer and its controller.
`timescale 1ns/1ps
module seq_link_monitor import reset_seq_pkg::*; #(
  parameter int CYC0 = CYC_MODE0,
  parameter int CYC1 = CYC_MODE1,
  parameter int CYC2 = CYC_MODE2,
  parameter int CYC3 = CYC_MODE3,
  parameter int CYC4 = CYC_MODE4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hard_reset_n,
  input wire logic ack_n,
  input wire logic ready,
  input wire logic int_n,
  input wire logic dev_mode_oe,
  input wire logic [2:0] mode_pin,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  int cnt;
  logic [2:0] md;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Counts edges since release and keeps the strapped mode.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      md <= 3'h0;
    end else if (!hard_reset_n) begin
      cnt <= 0;
      md <= mode_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Gives the start-up length of each mode.
  function automatic int expc(input logic [2:0] m);
    case (m)
      3'h0: return CYC0;
      3'h1: return CYC1;
      3'h2: return CYC2;
      3'h3: return CYC3;
      3'h4: return CYC4;
      default: return CYC_MODE5;
    endcase
  endfunction
  a_reset_halts: assert property (!hard_reset_n |-> !ready && int_n && !reg_rvalid)
    else $error("device active in hard reset");
  a_pins_turn_out: assert property ($rose(hard_reset_n) && md != 3'h7 |-> ##[1:5] dev_mode_oe)
    else $error("mode pins not driven after release");
  a_reserved_idle: assert property (hard_reset_n && md == 3'h7 |-> !ready)
    else $error("ready in reserved mode");
  a_time_low: assert property ($rose(ready) && md < 3'h3 |-> cnt == expc(md))
    else $error("start-up length wrong");
  a_time_high: assert property ($rose(ready) && md > 3'h2 && md < 3'h6 |-> cnt == expc(md))
    else $error("start-up length wrong");
  a_reg_answer: assert property (reg_rd && ready |=> reg_rvalid || !hard_reset_n)
    else $error("register read unanswered");
  a_mode_readback: assert property (reg_rvalid && reg_addr == ADDR_SELFTEST_HIGH |-> reg_rdata == {md, 5'h0})
    else $error("mode readback wrong");
  a_int_holds: assert property (hard_reset_n && !int_n && ack_n && $past(ack_n) && $past(ack_n, 2)
    |=> !int_n || !hard_reset_n)
    else $error("interrupt released without acknowledge");
  a_int_clears: assert property (!int_n && $fell(ack_n) |-> ##[1:5] int_n)
    else $error("interrupt not released by acknowledge");
  c_ready: cover property ($rose(ready));
  c_fault: cover property ($fell(int_n));
  c_readback: cover property (reg_rvalid && reg_addr == ADDR_SELFTEST_HIGH);
endmodule

/* testbench/reset_startup_sequencer_tb.sv */
// Bench: boots the sequencer pair in start-up modes 0 to 6 over AXI4-Lite.
`timescale 1ns/1ps
module reset_startup_sequencer_tb import reset_seq_pkg::*;;
  logic mclk = 1'b0, rst = 1'b1, ram_fault_inject = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bus_active, safe_state;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] rresp;
  logic ee_in = 1'b0;
  int checks = 0, fail_count = 0, cyc = 0;
  // Short start-up lengths; modes 1 and 3 leave room for both EEPROM passes.
  localparam int C0 = 200, C1 = 1400, C2 = 300, C3 = 1500, C4 = 150;
  seq_link_if link();
  seq_controller i_seq_controller (.mclk(mclk), .rst(rst), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  startup_sequencer #(.CYC0(C0), .CYC1(C1), .CYC2(C2), .CYC3(C3), .CYC4(C4))
    i_startup_sequencer (.mclk(mclk), .rst(rst), .link(link), .eeprom_serial_in(ee_in),
    .ram_fault_inject(ram_fault_inject), .bus_active(bus_active), .safe_state(safe_state));
  seq_link_monitor #(.CYC0(C0), .CYC1(C1), .CYC2(C2), .CYC3(C3), .CYC4(C4))
    i_seq_link_monitor (.mclk(mclk), .rst(rst), .hard_reset_n(link.hard_reset_n),
    .ack_n(link.ack_n), .ready(link.ready), .int_n(link.int_n),
    .dev_mode_oe(link.dev_mode_oe), .mode_pin(link.mode_pin), .reg_rd(link.reg_rd),
    .reg_addr(link.reg_addr), .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));
  // Makes the 25 MHz clock.
  initial begin
    forever #20 mclk = ~mclk;
  end
  // Compares one value and counts it.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Writes one controller register.
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid);
  endtask
  // Reads one controller register.
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rready <= 1'b0;
  endtask
  // Reads a device register; the answer lands two cycles after the write.
  task dev_rd(input logic [15:0] a, output logic [31:0] v);
    wr(DEV_ADDR_OFF, {16'h0, a});
    repeat (3) @(posedge mclk);
    rd(DEV_DATA_OFF, v);
  endtask
  // Holds hard reset with the mode strapped, then releases it.
  task boot(input logic [2:0] m);
    wr(CTRL_OFF, {27'h0, m, 2'b00});
    repeat (4) @(posedge mclk);
    wr(CTRL_OFF, {27'h0, m, 2'b01});
  endtask
  // Prints the counts and the verdict, then stops.
  task conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      conclude();
    end
  end
  // Main sequence.
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int m = 0; m < 6; m++) begin
      boot(m[2:0]);
      d = 32'h0;
      while (d[0] !== 1'b1) rd(STATUS_OFF, d);
      chk({31'h0, bus_active}, 32'h0);
      dev_rd(ADDR_SELFTEST_HIGH, d);
      chk(d, {23'h0, 1'b1, m[2:0], 5'h0});
      wr(CTRL_OFF, {27'h0, m[2:0], 2'b11});
      repeat (START_LAT + 2) @(posedge mclk);
      chk({31'h0, bus_active}, 32'h1);
      $display("mode %0d start-up done", m);
    end
    ram_fault_inject <= 1'b1;
    boot(MODE_RAM_TEST);
    repeat (150) @(posedge mclk);
    chk({31'h0, safe_state}, 32'h1);
    rd(STATUS_OFF, d);
    chk(d, 32'h0);
    dev_rd(ADDR_PENDING, d);
    chk(d, 32'h108);
    dev_rd(ADDR_PENDING, d);
    chk(d, 32'h100);
    dev_rd(16'h0001, d);
    chk(d, 32'h101);
    wr(SOFT_RST_OFF, {29'h0, MODE_LAST_DATA});
    dev_rd(16'h0001, d);
    chk(d, 32'h100);
    wr(CTRL_OFF, 32'h39);
    repeat (8) @(posedge mclk);
    rd(STATUS_OFF, d);
    chk(d, 32'h2);
    ram_fault_inject <= 1'b0;
    $display("self test fault done");
    boot(MODE_RESERVED);
    wstrb <= 4'he;
    wr(CTRL_OFF, 32'h0);
    wstrb <= 4'hf;
    rd(CTRL_OFF, d);
    chk(d, {27'h0, MODE_RAM_TEST, 2'h1});
    d = 32'h0;
    while (d[0] !== 1'b1) rd(STATUS_OFF, d);
    dev_rd(ADDR_SELFTEST_HIGH, d);
    chk(d, {23'h0, 1'b1, MODE_RAM_TEST, 5'h0});
    rd(8'h40, d);
    chk(d, 32'h0);
    chk({30'h0, rresp}, {30'h0, RESP_SLVERR});
    $display("reserved mode done");
    ee_in <= 1'b1;
    boot(3'h1);
    repeat (1300) @(posedge mclk);
    chk({31'h0, safe_state}, 32'h1);
    dev_rd(ADDR_PENDING, d);
    chk(d, 32'h110);
    $display("checksum fault done");
    conclude();
  end
endmodule
